// file: pkg/amdp_consts.svh
// Constants for the multi-sector, DMA and power-control command block.
`ifndef AMDP_CONSTS_SVH
`define AMDP_CONSTS_SVH
// ****************************************
// Register offsets (byte addresses).
// ****************************************
`define AMDP_OFF_FEATURE  12'h000
`define AMDP_OFF_SECTCNT  12'h004
`define AMDP_OFF_LBA_LO   12'h008
`define AMDP_OFF_LBA_HI   12'h00C
`define AMDP_OFF_HEAD     12'h010
`define AMDP_OFF_COMMAND  12'h014
`define AMDP_OFF_STATUS   12'h018
`define AMDP_OFF_CONTROL  12'h01C
// ****************************************
// Command codes.
// ****************************************
`define AMDP_CMD_SETMUL   8'hC6
`define AMDP_CMD_RD_DMA0  8'hC8
`define AMDP_CMD_RD_DMA1  8'hC9
`define AMDP_CMD_WR_DMA0  8'hCA
`define AMDP_CMD_WR_DMA1  8'hCB
`define AMDP_CMD_RD_EXT   8'h25
`define AMDP_CMD_WR_EXT   8'h35
`define AMDP_CMD_SETFEAT  8'hEF
`define AMDP_PWR_NIBBLE   4'hE
`define AMDP_SUB_STBY_IMM 4'h0
`define AMDP_SUB_IDLE_IMM 4'h1
`define AMDP_SUB_STBY     4'h2
`define AMDP_SUB_IDLE     4'h3
`define AMDP_SUB_QUERY    4'h5
`define AMDP_SUB_SLEEP    4'h6
`define AMDP_FEAT_KEEP    8'h66
`define AMDP_FEAT_REVERT  8'hCC
// ****************************************
// Field positions and reset values.
// ****************************************
`define AMDP_HEAD_LBA_BIT 6
`define AMDP_CTL_SRST_BIT 2
`define AMDP_BLK_DEFAULT  5'h10
`define AMDP_QUERY_IDLE   8'hFF
`define AMDP_QUERY_STBY   8'h00
// ****************************************
// Timing.
// ****************************************
`define AMDP_CLK_HZ       10000000
`define AMDP_TICK_S       5
`define AMDP_TICK_CYC     (`AMDP_TICK_S * `AMDP_CLK_HZ)
`endif

// file: pkg/amdp_pkg.sv
// Types for the multi-sector, DMA and power-control command block.
package amdp_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_SPIN, ST_XFER, ST_SECT, ST_DONE} amdp_state_e;
  typedef enum logic [1:0] {PM_SPINUP, PM_IDLE, PM_STANDBY, PM_SLEEP} amdp_pm_e;
  typedef logic [7:0] amdp_byte_t;
endpackage : amdp_pkg

// file: design/amdp_core.sv
// Command execution for block size, DMA transfers and power control.
`timescale 1ns/10ps
`include "amdp_consts.svh"
module amdp_core #(
  parameter int  SECTOR_WORDS = 256,
  parameter int  SPINUP_CYC   = 16,
  parameter int  TICK_CYC     = `AMDP_TICK_CYC
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // DMA pins.
  output logic             dmarq,
  input  wire logic        dmack,
  // Media error from the disk channel.
  input  wire logic        media_err,
  // Interrupt pin.
  output logic             intrq,
  // Power mode.
  output amdp_pkg::amdp_pm_e pm_mode
);
  import amdp_pkg::*;

  // ****************************************
  // State.
  // ****************************************
  amdp_state_e state_ff;
  amdp_pm_e    pm_ff;
  amdp_byte_t  feature_reg_ff;
  amdp_byte_t  cmd_ff;
  amdp_byte_t  head_reg_ff;
  logic [15:0] sector_count_reg_ff;
  logic [47:0] lba_ff;
  logic [4:0]  block_ff;
  logic        multi_en_ff, keep_mode_ff, err_ff, abrt_ff, unc_ff, intrq_ff;
  logic [16:0] rem_ff;
  logic [15:0] wcnt_ff, spin_ff, tmr_ff, tmr_load_ff;
  logic [31:0] presc_ff;
  logic        ack_s1_ff, ack_s2_ff, ack_s3_ff, err_s1_ff, err_s2_ff;
  logic        wr_en, rd_en, cmd_go, srst, stat_rd, bsy, drdy;
  logic        ack_edge, is_dma, is_ext, is_pwr, blk_ok, tick, spin_done;
  logic [3:0]  sub;
  logic [27:0] lba28_inc;
  logic [15:0] tmr_code;

  // ****************************************
  // Decode.
  // ****************************************
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign cmd_go  = wr_en & (paddr == `AMDP_OFF_COMMAND) & (state_ff == ST_IDLE);
  assign srst    = wr_en & (paddr == `AMDP_OFF_CONTROL) & pwdata[`AMDP_CTL_SRST_BIT];
  assign stat_rd = rd_en & (paddr == `AMDP_OFF_STATUS);
  assign sub     = cmd_ff[3:0];
  assign is_pwr  = cmd_ff[7:4] == `AMDP_PWR_NIBBLE;
  assign is_ext  = (cmd_ff == `AMDP_CMD_RD_EXT) | (cmd_ff == `AMDP_CMD_WR_EXT);
  assign is_dma  = is_ext | (cmd_ff == `AMDP_CMD_RD_DMA0) | (cmd_ff == `AMDP_CMD_RD_DMA1)
                 | (cmd_ff == `AMDP_CMD_WR_DMA0) | (cmd_ff == `AMDP_CMD_WR_DMA1);
  assign blk_ok  = (sector_count_reg_ff[7:0] == 8'h01) | (sector_count_reg_ff[7:0] == 8'h02)
                 | (sector_count_reg_ff[7:0] == 8'h04) | (sector_count_reg_ff[7:0] == 8'h08)
                 | (sector_count_reg_ff[7:0] == 8'h10);
  assign bsy       = (state_ff != ST_IDLE) & (state_ff != ST_XFER);
  assign dmarq     = state_ff == ST_XFER;
  assign drdy      = (pm_ff == PM_IDLE) | (pm_ff == PM_STANDBY);
  assign ack_edge  = ack_s2_ff & ~ack_s3_ff;
  assign tick      = presc_ff == 32'(TICK_CYC - 1);
  assign spin_done = spin_ff == 16'(SPINUP_CYC - 1);
  assign lba28_inc = {head_reg_ff[3:0], lba_ff[23:0]} + 28'h0000001;
  assign intrq     = intrq_ff;
  assign pm_mode   = pm_ff;
  assign pready    = 1'b1;

  // Stand-by timer reload in 5 s ticks.
  always_comb begin
    tmr_code = 16'h0000;
    if (sector_count_reg_ff[7:0] <= 8'd240) begin
      tmr_code = {8'h00, sector_count_reg_ff[7:0]};
    end else if (sector_count_reg_ff[7:0] <= 8'd251) begin
      tmr_code = 16'(({8'h00, sector_count_reg_ff[7:0]} - 16'd240) * 16'd360);
    end else if (sector_count_reg_ff[7:0] == 8'd252) begin
      tmr_code = 16'd252;
    end else if (sector_count_reg_ff[7:0] == 8'd253) begin
      tmr_code = 16'd7200;
    end else if (sector_count_reg_ff[7:0] == 8'd255) begin
      tmr_code = 16'd255;
    end
  end

  // ****************************************
  // APB read data.
  // ****************************************
  always_comb begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    unique case (paddr)
      `AMDP_OFF_FEATURE: prdata = {24'h000000, feature_reg_ff};
      `AMDP_OFF_SECTCNT: prdata = {16'h0000, sector_count_reg_ff};
      `AMDP_OFF_LBA_LO:  prdata = {8'h00, lba_ff[23:0]};
      `AMDP_OFF_LBA_HI:  prdata = {8'h00, lba_ff[47:24]};
      `AMDP_OFF_HEAD:    prdata = {24'h000000, head_reg_ff};
      `AMDP_OFF_COMMAND: prdata = {24'h000000, cmd_ff};
      `AMDP_OFF_STATUS:  prdata = {pm_ff, multi_en_ff, block_ff, 1'b0, unc_ff, 3'h0, abrt_ff,
                                   2'h0, 8'h00, bsy, drdy, 3'h0, dmarq, 1'b0, err_ff};
      `AMDP_OFF_CONTROL: prdata = {31'h00000000, keep_mode_ff};
      default:           pslverr = psel & penable;
    endcase
  end

  // ****************************************
  // Pin synchronisers.
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ack_s3_ff <= 1'b0;
      err_s1_ff <= 1'b0;
      err_s2_ff <= 1'b0;
    end else begin
      ack_s1_ff <= dmack;
      ack_s2_ff <= ack_s1_ff;
      ack_s3_ff <= ack_s2_ff;
      err_s1_ff <= media_err;
      err_s2_ff <= err_s1_ff;
    end
  end

  // ****************************************
  // Command sequencer.
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cmd_ff   <= 8'h00;
      rem_ff   <= 17'h00000;
      wcnt_ff  <= 16'h0000;
    end else if (srst) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (cmd_go) begin
            cmd_ff   <= pwdata[7:0];
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          rem_ff  <= is_ext ? ((sector_count_reg_ff == 16'h0000) ? 17'h10000
                                : {1'b0, sector_count_reg_ff})
                            : ((sector_count_reg_ff[7:0] == 8'h00) ? 17'h00100
                                : {9'h000, sector_count_reg_ff[7:0]});
          wcnt_ff <= 16'h0000;
          if (pm_ff == PM_SLEEP) begin
            state_ff <= ST_DONE;
          end else if (is_dma & ~(is_ext & ~head_reg_ff[`AMDP_HEAD_LBA_BIT])) begin
            state_ff <= ST_SPIN;
          end else if (is_pwr & ((sub == `AMDP_SUB_IDLE_IMM) | (sub == `AMDP_SUB_IDLE))) begin
            state_ff <= ST_SPIN;
          end else begin
            state_ff <= ST_DONE;
          end
        end
        ST_SPIN: begin
          if (pm_ff == PM_IDLE) begin
            state_ff <= is_dma ? ST_XFER : ST_DONE;
          end
        end
        ST_XFER: begin
          if (ack_edge) begin
            if (wcnt_ff == 16'(SECTOR_WORDS - 1)) begin
              wcnt_ff  <= 16'h0000;
              state_ff <= ST_SECT;
            end else begin
              wcnt_ff <= wcnt_ff + 16'h0001;
            end
          end
        end
        ST_SECT: begin
          rem_ff   <= rem_ff - 17'h00001;
          state_ff <= (err_s2_ff | (rem_ff == 17'h00001)) ? ST_DONE : ST_XFER;
        end
        ST_DONE: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Task-file registers.
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      feature_reg_ff      <= 8'h00;
      sector_count_reg_ff <= 16'h0000;
      lba_ff              <= 48'h000000000000;
      head_reg_ff         <= 8'h00;
    end else begin
      if (wr_en & (state_ff == ST_IDLE)) begin
        unique case (paddr)
          `AMDP_OFF_FEATURE: feature_reg_ff <= pwdata[7:0];
          `AMDP_OFF_SECTCNT: sector_count_reg_ff <= pwdata[15:0];
          `AMDP_OFF_LBA_LO:  lba_ff[23:0] <= pwdata[23:0];
          `AMDP_OFF_LBA_HI:  lba_ff[47:24] <= pwdata[23:0];
          `AMDP_OFF_HEAD:    head_reg_ff <= pwdata[7:0];
          default:           ;
        endcase
      end
      if ((state_ff == ST_EXEC) & is_pwr & (sub == `AMDP_SUB_QUERY)) begin
        sector_count_reg_ff <= {sector_count_reg_ff[15:8],
                                (pm_ff == PM_IDLE) ? `AMDP_QUERY_IDLE
                                                   : `AMDP_QUERY_STBY};
      end
      if ((state_ff == ST_SECT) & ~err_s2_ff) begin
        if (rem_ff == 17'h00001) begin
          sector_count_reg_ff <= 16'h0000;
        end else if (is_ext) begin
          lba_ff <= lba_ff + 48'h000000000001;
        end else begin
          lba_ff[23:0]     <= lba28_inc[23:0];
          head_reg_ff[3:0] <= lba28_inc[27:24];
        end
      end
    end
  end

  // ****************************************
  // Block size and feature mode.
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      block_ff     <= `AMDP_BLK_DEFAULT;
      multi_en_ff  <= 1'b1;
      keep_mode_ff <= 1'b0;
    end else if (srst) begin
      if (~keep_mode_ff) begin
        block_ff    <= `AMDP_BLK_DEFAULT;
        multi_en_ff <= 1'b1;
      end
    end else if ((state_ff == ST_EXEC) & (pm_ff != PM_SLEEP)) begin
      if (cmd_ff == `AMDP_CMD_SETMUL) begin
        if (sector_count_reg_ff[7:0] == 8'h00) begin
          multi_en_ff <= 1'b0;
        end else if (blk_ok) begin
          block_ff    <= sector_count_reg_ff[4:0];
          multi_en_ff <= 1'b1;
        end else begin
          multi_en_ff <= 1'b0;
        end
      end else if ((cmd_ff == `AMDP_CMD_SETFEAT) & (feature_reg_ff == `AMDP_FEAT_KEEP)) begin
        keep_mode_ff <= 1'b1;
      end else if ((cmd_ff == `AMDP_CMD_SETFEAT) & (feature_reg_ff == `AMDP_FEAT_REVERT)) begin
        keep_mode_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Error status and interrupt.
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      err_ff   <= 1'b0;
      abrt_ff  <= 1'b0;
      unc_ff   <= 1'b0;
      intrq_ff <= 1'b0;
    end else begin
      if (state_ff == ST_EXEC) begin
        abrt_ff <= (pm_ff == PM_SLEEP)
                 | ((cmd_ff == `AMDP_CMD_SETMUL) & (sector_count_reg_ff[7:0] != 8'h00) & ~blk_ok)
                 | (is_ext & ~head_reg_ff[`AMDP_HEAD_LBA_BIT])
                 | ~(is_dma | (cmd_ff == `AMDP_CMD_SETMUL) | (cmd_ff == `AMDP_CMD_SETFEAT)
                     | (is_pwr & ((sub <= `AMDP_SUB_IDLE) | (sub == `AMDP_SUB_QUERY)
                                  | (sub == `AMDP_SUB_SLEEP))));
        unc_ff  <= 1'b0;
      end else if ((state_ff == ST_SECT) & err_s2_ff) begin
        unc_ff <= 1'b1;
      end
      err_ff   <= abrt_ff | unc_ff;
      intrq_ff <= (state_ff == ST_DONE) | (intrq_ff & ~stat_rd & ~cmd_go & ~srst);
    end
  end

  // ****************************************
  // Power mode, spin-up and stand-by timer.
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pm_ff <= PM_SPINUP;
    end else if (srst) begin
      if (pm_ff == PM_SLEEP) begin
        pm_ff <= PM_STANDBY;
      end
    end else if ((state_ff == ST_EXEC) & (pm_ff != PM_SLEEP) & is_pwr
                 & ((sub == `AMDP_SUB_STBY_IMM) | (sub == `AMDP_SUB_STBY))) begin
      pm_ff <= PM_STANDBY;
    end else if ((state_ff == ST_EXEC) & (pm_ff != PM_SLEEP) & is_pwr
                 & (sub == `AMDP_SUB_SLEEP)) begin
      pm_ff <= PM_SLEEP;
    end else if ((state_ff == ST_SPIN) & (pm_ff == PM_STANDBY)) begin
      pm_ff <= PM_SPINUP;
    end else if ((pm_ff == PM_SPINUP) & spin_done) begin
      pm_ff <= PM_IDLE;
    end else if ((pm_ff == PM_IDLE) & (tmr_load_ff != 16'h0000) & (tmr_ff == 16'h0000)) begin
      pm_ff <= PM_STANDBY;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      spin_ff <= 16'h0000;
    end else begin
      spin_ff <= ((pm_ff == PM_SPINUP) & ~spin_done) ? spin_ff + 16'h0001 : 16'h0000;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmr_load_ff <= 16'h0000;
      tmr_ff      <= 16'h0000;
      presc_ff    <= 32'h00000000;
    end else begin
      presc_ff <= tick ? 32'h00000000 : presc_ff + 32'h00000001;
      if ((state_ff == ST_EXEC) & is_pwr & (pm_ff != PM_SLEEP)
          & ((sub == `AMDP_SUB_STBY) | (sub == `AMDP_SUB_IDLE))) begin
        tmr_load_ff <= tmr_code;
        tmr_ff      <= tmr_code;
        presc_ff    <= 32'h00000000;
      end else if ((state_ff != ST_IDLE) | (pm_ff != PM_IDLE)) begin
        tmr_ff <= tmr_load_ff;
      end else if (tick & (tmr_ff != 16'h0000)) begin
        tmr_ff <= tmr_ff - 16'h0001;
      end
    end
  end

  // ****************************************
  // Assertions.
  // ****************************************
  a_busy_or_drq: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff != ST_IDLE) |-> (bsy | dmarq)) else $error("Neither busy nor request in command.");
  a_accept_busy: assert property (@(posedge core_clk) disable iff (rst)
    cmd_go & ~srst |=> bsy ##1 bsy) else $error("Command not marked busy.");
  a_intr_once: assert property (@(posedge core_clk) disable iff (rst)
    $rose(intrq) |-> $past(state_ff == ST_DONE)) else $error("Interrupt outside completion.");
  a_intr_done: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_DONE) & ~srst |=> intrq) else $error("No interrupt at completion.");
  a_block_legal: assert property (@(posedge core_clk) disable iff (rst)
    multi_en_ff |-> (block_ff inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10}))
    else $error("Illegal block size enabled.");
  a_block_zero: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_EXEC) & (cmd_ff == `AMDP_CMD_SETMUL) & (pm_ff != PM_SLEEP) & ~srst
    & (sector_count_reg_ff[7:0] == 8'h00) |=> ~multi_en_ff) else $error("Zero did not disable.");
  a_query_value: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_EXEC) & is_pwr & (sub == `AMDP_SUB_QUERY) |=>
    sector_count_reg_ff[7:0] == (($past(pm_ff) == PM_IDLE) ? 8'hFF : 8'h00))
    else $error("Wrong power query value.");
  a_spin_idle: assert property (@(posedge core_clk) disable iff (rst)
    $rose(pm_ff == PM_SPINUP) |-> (pm_ff == PM_SPINUP) [*2]) else $error("Spin-up too short.");
  a_xfer_idle: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_XFER) |-> (pm_ff == PM_IDLE)) else $error("Transfer while spun down.");
  a_done_count: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_SECT) & ~err_s2_ff & (rem_ff == 17'h00001) & ~srst |=>
    (sector_count_reg_ff == 16'h0000) & (state_ff == ST_DONE)) else $error("Bad completion.");
endmodule : amdp_core

// file: tb/amdp_host_dma.sv
// Host DMA channel model that answers the device's DMA requests word by word.
`timescale 1ns/10ps
module amdp_host_dma (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst,
  // DMA pins.
  input  wire logic       dmarq,
  output logic            dmack,
  // Cycles of delay before each word.
  input  wire logic [3:0] gap
);
  int words = 0;
  // ****************************************
  // Word acknowledges, one per request seen.
  // ****************************************
  initial begin
    dmack = 1'b0;
    forever begin
      @(posedge core_clk);
      if (rst === 1'b0 && dmarq === 1'b1) begin
        repeat (gap) @(posedge core_clk);
        dmack <= 1'b1;
        repeat (2) @(posedge core_clk);
        dmack <= 1'b0;
        words++;
        repeat (3) @(posedge core_clk);
      end
    end
  end
endmodule : amdp_host_dma

// file: tb/tb_top.sv
// Self-checking bench for the block-size, DMA and power command block.
`timescale 1ns/10ps
`include "amdp_consts.svh"
module tb_top;
  import amdp_pkg::*;
  localparam logic [11:0] A_SC = `AMDP_OFF_SECTCNT, A_ST = `AMDP_OFF_STATUS;
  localparam logic [11:0] A_LO = `AMDP_OFF_LBA_LO, A_HD = `AMDP_OFF_HEAD, A_CT = `AMDP_OFF_CONTROL;
  logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        media_err = 1'b0, pready, pslverr, dmarq, dmack, intrq, irq_q, serr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, st;
  logic [3:0]  gap = 4'h0;
  logic [4:0]  blk;
  amdp_pm_e    pm_mode, pm;
  int          errors = 0, cmp_count = 0, irq_n = 0, seed = 32'h49CA3B25;
  int          i, n0, w0, v, start;
  bit          ok;
  logic [7:0]  cd[6] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'h25, 8'h35};
  logic [7:0]  pw[7] = '{8'hE0, 8'hE5, 8'hE1, 8'hE5, 8'hE2, 8'hE3, 8'hE0};
  int          sz[8] = '{1, 2, 4, 8, 16, 0, 3, 32};
  // ****************************************
  // Clock, design and host model.
  // ****************************************
  always #50 core_clk = ~core_clk;
  amdp_core #(.SECTOR_WORDS(4), .SPINUP_CYC(16), .TICK_CYC(20)) dut_u (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dmarq(dmarq), .dmack(dmack), .media_err(media_err), .intrq(intrq), .pm_mode(pm_mode));
  amdp_host_dma hd_u (.core_clk(core_clk), .rst(rst), .dmarq(dmarq), .dmack(dmack), .gap(gap));
  always @(posedge core_clk) begin
    if (intrq === 1'b1 && irq_q !== 1'b1) irq_n++;
    irq_q <= intrq;
  end
  // ****************************************
  // Checks and bus tasks.
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_pm(input amdp_pm_e e);
    chk({30'h0, pm_mode}, {30'h0, e});
  endtask : chk_pm
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [7:0] c);
    int n;
    apb(1'b1, `AMDP_OFF_COMMAND, {24'h0, c});
    for (n = 0; n < 3000 && intrq !== 1'b1; n++) @(posedge core_clk);
    chk(n < 3000, 1'b1);
    apb(1'b0, A_ST, 32'h0);
    st = rd;
  endtask : cmd
  task automatic soft_reset;
    apb(1'b1, A_CT, 32'h4);
    apb(1'b1, A_CT, 32'h0);
    repeat (20) @(posedge core_clk);
  endtask : soft_reset
  task automatic conclude;
    $display("Compared %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  initial begin
    #2000000;
    errors++;
    conclude();
  end
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    repeat (16) @(posedge core_clk);
    chk_pm(PM_SPINUP);
    rst <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk_pm(PM_IDLE);
    apb(1'b0, A_ST, 32'h0);
    chk(rd[29:24], 6'h30);
    apb(1'b0, 12'h040, 32'h0);
    chk(serr, 1'b1);
    blk = 5'h10;
    for (i = 0; i < 9; i++) begin
      v = (i < 8) ? sz[i] : ($random(seed) & 31);
      ok = v inside {1, 2, 4, 8, 16};
      apb(1'b1, A_SC, v);
      cmd(`AMDP_CMD_SETMUL);
      if (ok) blk = v[4:0];
      chk(st[29], ok);
      chk(st[28:24], blk);
      chk(st[18], (v != 0) && !ok);
    end
    for (i = 0; i < 2; i++) begin
      apb(1'b1, A_SC, 32'h4);
      cmd(`AMDP_CMD_SETMUL);
      apb(1'b1, `AMDP_OFF_FEATURE, i ? `AMDP_FEAT_REVERT : `AMDP_FEAT_KEEP);
      cmd(`AMDP_CMD_SETFEAT);
      soft_reset();
      apb(1'b0, A_ST, 32'h0);
      chk(rd[29:24], i ? 6'h30 : 6'h24);
    end
    pm = PM_IDLE;
    for (i = 0; i < 7; i++) begin
      v = (pw[i] inside {8'hE2, 8'hE3}) ? 0 : 8'h5A;
      apb(1'b1, A_SC, v);
      cmd(pw[i]);
      if (pw[i] inside {8'hE0, 8'hE2}) pm = PM_STANDBY;
      if (pw[i] inside {8'hE1, 8'hE3}) pm = PM_IDLE;
      if (pw[i] == 8'hE5) v = (pm == PM_IDLE) ? 8'hFF : 8'h00;
      apb(1'b0, A_SC, 32'h0);
      chk(rd[7:0], v);
      chk_pm(pm);
      chk(st[6], 1'b1);
    end
    for (i = 0; i < 6; i++) begin
      start = $random(seed) & 32'hFFFFF;
      gap <= 4'($random(seed) & 3);
      apb(1'b1, A_HD, 32'h40);
      apb(1'b1, A_LO, start);
      apb(1'b1, `AMDP_OFF_LBA_HI, 32'h0);
      apb(1'b1, A_SC, 32'h0);
      apb(1'b1, A_SC, 32'h2);
      n0 = irq_n;
      w0 = hd_u.words;
      cmd(cd[i]);
      chk(irq_n - n0, 1);
      chk(dmarq, 1'b0);
      chk(hd_u.words - w0, 8);
      chk(st[0], 1'b0);
      chk_pm(PM_IDLE);
      apb(1'b0, A_LO, 32'h0);
      chk(rd, start + 1);
      apb(1'b0, A_SC, 32'h0);
      chk(rd[7:0], 8'h00);
    end
    apb(1'b1, A_HD, 32'h0);
    cmd(`AMDP_CMD_RD_EXT);
    chk(st[18], 1'b1);
    apb(1'b1, A_HD, 32'h40);
    apb(1'b1, A_SC, 32'h2);
    media_err <= 1'b1;
    cmd(`AMDP_CMD_WR_DMA0);
    media_err <= 1'b0;
    chk(st[22], 1'b1);
    apb(1'b0, A_LO, 32'h0);
    chk(rd, start + 1);
    apb(1'b1, A_SC, 32'h1);
    cmd(8'hE3);
    repeat (80) @(posedge core_clk);
    chk_pm(PM_STANDBY);
    cmd(8'hE6);
    chk_pm(PM_SLEEP);
    cmd(8'hE5);
    chk(st[18], 1'b1);
    soft_reset();
    chk_pm(PM_STANDBY);
    cmd(8'hE4);
    chk(st[18], 1'b1);
    conclude();
  end
endmodule : tb_top
